//--- logic/brst_selftest_ctrl.sv
/*
  Resistance self-test controller: register file on Avalon-MM, switch
  controls and the modulation clock for the bioimpedance channel.
  Assumes a one-cycle master clock enable pulse and a synchronous master.
*/
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module brst_selftest_ctrl (
  input  wire logic                 clk_in,
  input  wire logic                 srst_in,
  input  wire logic                 mstr_tick_in,
  input  wire logic [9:0]           avs_address_in,
  input  wire logic                 avs_read_in,
  input  wire logic                 avs_write_in,
  input  wire logic [3:0]           avs_byteenable_in,
  input  wire logic [31:0]          avs_writedata_in,
  output logic      [31:0]          avs_readdata_out,
  output logic                      avs_waitrequest_out,
  output var brst_pkg::brst_switch_t switch_out,
  output logic [2:0]                nominal_sel_out,
  output logic [2:0]                modulated_sel_out,
  output logic                      input_p_open_out,
  output logic                      input_n_open_out,
  output logic [23:0]               chan_cfg_out,
  output logic                      chan_changed_out,
  output logic                      resync_out
);
  import brst_pkg::*;

  logic [23:0]    mux_cfg_reg;
  logic [23:0]    chan_cfg_reg;
  logic           cal_en_reg;
  logic           chan_dirty_reg;
  logic           ack_reg;
  logic [7:0]     word_idx;
  logic           req;
  logic           wr_fire;
  logic           rd_fire;
  logic [31:0]    wmask;
  logic [23:0]    mux_next;
  logic [23:0]    chan_next;
  logic [31:0]    rdata_next;
  logic           mod_clk;
  logic           selftest_active;
  logic           modulating;
  brst_bist_cfg_t bist;

  // ==========================================================
  // Bus decode: one wait cycle, answer on the second edge
  assign word_idx            = avs_address_in[9:2];
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_reg;
  assign wr_fire             = avs_write_in & ack_reg;
  assign rd_fire             = avs_read_in & ack_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_comb begin
    wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
             {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    mux_next  = ((mux_cfg_reg & ~wmask[23:0]) | (avs_writedata_in[23:0] & wmask[23:0]))
                & BRST_MUX_MASK;
    chan_next = (chan_cfg_reg & ~wmask[23:0]) | (avs_writedata_in[23:0] & wmask[23:0]);
  end

  // ==========================================================
  // Input mux configuration register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mux_cfg_reg <= BRST_MUX_RESET;
    end else if (wr_fire && word_idx == BRST_IDX_MUX_CFG) begin
      mux_cfg_reg <= mux_next;
    end
  end

  // ==========================================================
  // Channel configuration register and change flag
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chan_cfg_reg <= BRST_CHAN_RESET;
    end else if (wr_fire && word_idx == BRST_IDX_CHAN_CFG) begin
      chan_cfg_reg <= chan_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chan_dirty_reg <= 1'b0;
    end else if (wr_fire && word_idx == BRST_IDX_CHAN_CFG) begin
      chan_dirty_reg <= 1'b1;
    end else if (resync_out) begin
      chan_dirty_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Control register: calibration enable and resync strobe
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cal_en_reg <= 1'b0;
      resync_out <= 1'b0;
    end else begin
      resync_out <= wr_fire && word_idx == BRST_IDX_CTRL &&
                    avs_byteenable_in[0] && avs_writedata_in[BRST_RESYNC_BIT];
      if (wr_fire && word_idx == BRST_IDX_CTRL && avs_byteenable_in[0]) begin
        cal_en_reg <= avs_writedata_in[BRST_CAL_EN_BIT];
      end
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    unique case (word_idx)
      BRST_IDX_MUX_CFG:  rdata_next = {8'h00, mux_cfg_reg};
      BRST_IDX_CHAN_CFG: rdata_next = {8'h00, chan_cfg_reg};
      BRST_IDX_CTRL:     rdata_next = {31'h0, cal_en_reg};
      BRST_IDX_STATUS:   rdata_next = {28'h0, chan_dirty_reg, mod_clk,
                                       modulating, selftest_active};
      default:           rdata_next = BRST_UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in && !ack_reg) begin
      avs_readdata_out <= rdata_next;
    end
  end

  // ==========================================================
  // Self-test configuration and switch control
  always_comb begin
    bist.selftest_en   = mux_cfg_reg[BRST_EN_BIT];
    bist.nominal_sel   = mux_cfg_reg[BRST_RNOM_LSB +: 3];
    bist.modulated_sel = mux_cfg_reg[BRST_RMOD_LSB +: 3];
    bist.freq_sel      = mux_cfg_reg[BRST_FSEL_LSB +: 2];
    selftest_active    = bist.selftest_en & ~cal_en_reg;
    modulating         = selftest_active & ~bist.modulated_sel[2] &
                         (bist.modulated_sel != BRST_RMOD_RESERVED);
  end

  brst_mod_divider u_divider (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .mstr_tick_in (mstr_tick_in),
    .freq_sel_in  (bist.freq_sel),
    .mod_clk_out  (mod_clk)
  );

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      switch_out        <= '0;
      nominal_sel_out   <= 3'h0;
      modulated_sel_out <= 3'h4;
      input_p_open_out  <= 1'b1;
      input_n_open_out  <= 1'b1;
      chan_cfg_out      <= BRST_CHAN_RESET;
      chan_changed_out  <= 1'b0;
    end else begin
      switch_out.drive_iso_open        <= selftest_active;
      switch_out.drive_to_input_closed <= selftest_active;
      switch_out.bias_high_value       <= selftest_active;
      switch_out.mod_switch            <= modulating & mod_clk;
      nominal_sel_out   <= bist.nominal_sel;
      modulated_sel_out <= bist.modulated_sel;
      input_p_open_out  <= mux_cfg_reg[BRST_OPENP_BIT];
      input_n_open_out  <= mux_cfg_reg[BRST_OPENN_BIT];
      chan_cfg_out      <= chan_cfg_reg;
      chan_changed_out  <= chan_dirty_reg;
    end
  end

  // ==========================================================
  // Checks
  sw_follow_a: assert property (@(posedge clk_in) disable iff (srst_in)
    selftest_active |=> (switch_out.drive_iso_open && switch_out.drive_to_input_closed &&
                         switch_out.bias_high_value))
    else $error("Self-test switches not applied");
  cal_block_a: assert property (@(posedge clk_in) disable iff (srst_in)
    cal_en_reg |=> !switch_out.drive_to_input_closed)
    else $error("Self-test active with calibration voltages");
  bias_idle_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !selftest_active |=> !switch_out.bias_high_value)
    else $error("High bias applied without self-test");
  nomod_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (bist.modulated_sel[2] || !selftest_active) |=> !switch_out.mod_switch)
    else $error("Modulation switch closed while unmodulated");
  mux_wr_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_fire && word_idx == BRST_IDX_MUX_CFG && avs_byteenable_in[1])
    |=> mux_cfg_reg[BRST_EN_BIT] == $past(avs_writedata_in[BRST_EN_BIT]))
    else $error("Self-test enable not stored");
  chan_wr_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_fire && word_idx == BRST_IDX_CHAN_CFG && avs_byteenable_in == 4'hf)
    |=> chan_cfg_reg == $past(avs_writedata_in[23:0]))
    else $error("Channel configuration not stored");
  dirty_set_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_fire && word_idx == BRST_IDX_CHAN_CFG) |=> ##1 chan_changed_out)
    else $error("Channel change not flagged");
  rsel_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ##1 nominal_sel_out == $past(mux_cfg_reg[10:8]))
    else $error("Nominal select output mismatch");
  wait_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (req && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("Waitrequest held too long");
  st_c: cover property (@(posedge clk_in) disable iff (srst_in) $rose(selftest_active));
  mod_c: cover property (@(posedge clk_in) disable iff (srst_in) $rose(switch_out.mod_switch));
  rs_c: cover property (@(posedge clk_in) disable iff (srst_in) resync_out && chan_dirty_reg);
endmodule : brst_selftest_ctrl
`default_nettype wire

//--- logic/brst_pkg.sv
/*
  Package for the resistance self-test controller: register offsets,
  field positions, reset values and divider constants.
  Assumes a 24-bit register word carried on a 32-bit Avalon-MM bus.
*/
`default_nettype none
package brst_pkg;
  // ==========================================================
  // Register map (printed offsets are word indices)
  localparam logic [7:0]  BRST_IDX_MUX_CFG   = 8'h17;
  localparam logic [7:0]  BRST_IDX_CHAN_CFG  = 8'h18;
  localparam logic [7:0]  BRST_IDX_CTRL      = 8'h19;
  localparam logic [7:0]  BRST_IDX_STATUS    = 8'h1a;
  localparam int          BRST_ADDR_W        = 10;
  localparam int          BRST_REG_W         = 24;
  // ==========================================================
  // Field positions of the input mux configuration register
  localparam int          BRST_EN_BIT        = 11;
  localparam int          BRST_RNOM_LSB      = 8;
  localparam int          BRST_RMOD_LSB      = 4;
  localparam int          BRST_FSEL_LSB      = 0;
  localparam int          BRST_OPENP_BIT     = 21;
  localparam int          BRST_OPENN_BIT     = 20;
  // Writable mask of the mux register: x bits read as zero
  localparam logic [23:0] BRST_MUX_MASK      = 24'h3f3f73;
  // ==========================================================
  // Reset values and the reserved modulation code
  localparam logic [23:0] BRST_MUX_RESET     = 24'h300040;
  localparam logic [23:0] BRST_CHAN_RESET    = 24'h200000;
  localparam logic [2:0]  BRST_RMOD_RESERVED = 3'h3;
  // ==========================================================
  // Control register bits (own register)
  localparam int          BRST_CAL_EN_BIT    = 0;
  localparam int          BRST_RESYNC_BIT    = 1;
  // ==========================================================
  // Divider: half periods are 2^(12+2k) master clock cycles
  localparam int          BRST_DIV_BASE_EXP  = 13;
  localparam int          BRST_DIV_STEP_EXP  = 2;
  localparam int          BRST_DIV_W         = 19;
  localparam logic [31:0] BRST_UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic       selftest_en;
    logic [2:0] nominal_sel;
    logic [2:0] modulated_sel;
    logic [1:0] freq_sel;
  } brst_bist_cfg_t;

  typedef struct packed {
    logic drive_iso_open;
    logic drive_to_input_closed;
    logic bias_high_value;
    logic mod_switch;
  } brst_switch_t;
endpackage : brst_pkg
`default_nettype wire

//--- logic/brst_mod_divider.sv
/*
  Free-running modulation divider with 50% duty output.
  Assumes a master clock enable pulse in the system clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module brst_mod_divider #(
  parameter int DIV_W = brst_pkg::BRST_DIV_W
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       mstr_tick_in,
  input  wire logic [1:0] freq_sel_in,
  output logic            mod_clk_out
);
  import brst_pkg::*;
  logic [DIV_W-1:0] count_reg;
  logic [DIV_W-1:0] half_mask;
  logic             last_tick;

  // ==========================================================
  // Half-period mask: 2^(12+2*sel) master cycles
  always_comb begin
    half_mask = DIV_W'((32'h1 << (BRST_DIV_BASE_EXP - 1 +
                 BRST_DIV_STEP_EXP * int'(freq_sel_in))) - 32'h1);
    last_tick = ((count_reg & half_mask) == half_mask);
  end

  // ==========================================================
  // Counter and output toggle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count_reg   <= '0;
      mod_clk_out <= 1'b0;
    end else if (mstr_tick_in) begin
      count_reg <= count_reg + DIV_W'(1);
      if (last_tick) begin
        mod_clk_out <= ~mod_clk_out;
        count_reg   <= '0;
      end
    end
  end

  hp_duty_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (mstr_tick_in && !last_tick) |=> $stable(mod_clk_out))
    else $error("Modulation output moved before half period end");
  tog_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (mstr_tick_in && last_tick) |=> (mod_clk_out != $past(mod_clk_out)))
    else $error("Modulation output failed to toggle");
  tog_c: cover property (@(posedge clk_in) disable iff (srst_in) $rose(mod_clk_out));
endmodule : brst_mod_divider
`default_nettype wire

//--- tb/tb_brst_top.sv
/*
  Self-checking bench for the resistance self-test controller.
  Assumes the controller answers Avalon-MM with waitrequest and that
  its divider counts master clock ticks driven here by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import brst_pkg::*;
  // ==========================================================
  // Signals
  logic         clk_in            = 1'b0;
  logic         srst_in           = 1'b1;
  logic         mstr_tick_in      = 1'b0;
  logic         tick_all          = 1'b1;
  logic [9:0]   avs_address_in    = 10'h000;
  logic         avs_read_in       = 1'b0;
  logic         avs_write_in      = 1'b0;
  logic [3:0]   avs_byteenable_in = 4'hf;
  logic [31:0]  avs_writedata_in  = 32'h0;
  logic [31:0]  avs_readdata_out;
  logic         avs_waitrequest_out;
  brst_switch_t switch_out;
  logic [2:0]   nominal_sel_out;
  logic [2:0]   modulated_sel_out;
  logic         input_p_open_out;
  logic         input_n_open_out;
  logic [23:0]  chan_cfg_out;
  logic         chan_changed_out;
  logic         resync_out;
  int           err_total         = 0;
  int           n_tests           = 0;
  logic [31:0]  q;

  brst_selftest_ctrl uut (.clk_in(clk_in), .srst_in(srst_in), .mstr_tick_in(mstr_tick_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .switch_out(switch_out),
    .nominal_sel_out(nominal_sel_out), .modulated_sel_out(modulated_sel_out),
    .input_p_open_out(input_p_open_out), .input_n_open_out(input_n_open_out),
    .chan_cfg_out(chan_cfg_out), .chan_changed_out(chan_changed_out),
    .resync_out(resync_out));

  // ==========================================================
  // Clock and master tick
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    mstr_tick_in <= tick_all | ~mstr_tick_in;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in    <= a;
    avs_writedata_in  <= d;
    avs_byteenable_in <= be;
    avs_write_in      <= wr;
    avs_read_in       <= ~wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    if (n >= 100) err_total++;
    rq = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q & m, exp);
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle

  function automatic logic [31:0] mux(logic en, logic [2:0] rn, logic [2:0] rm, logic [1:0] fs);
    return {10'h0, 2'b11, 8'h0, en, rn, 1'b0, rm, 2'b00, fs};
  endfunction : mux

  task automatic meas(input int sel, input int tk, input bit lo_too);
    int h;
    int n;
    int half;
    half = ((1 << (13 + 2 * sel)) / 2) * tk;
    wr(10'h05c, mux(1'b1, 3'h0, 3'h0, sel[1:0]));
    tick_all <= (tk == 1);
    // Let the switch output follow the new setting so that no partial phase is timed
    settle();
    n = 0;
    while (switch_out.mod_switch === 1'b1 && n < 70000) begin
      @(posedge clk_in);
      n++;
    end
    while (switch_out.mod_switch !== 1'b1 && n < 70000) begin
      @(posedge clk_in);
      n++;
    end
    h = 0;
    while (switch_out.mod_switch === 1'b1 && h < 70000) begin
      @(posedge clk_in);
      h++;
    end
    chk(h, half);
    if (lo_too) begin
      h = 0;
      while (switch_out.mod_switch === 1'b0 && h < 70000) begin
        @(posedge clk_in);
        h++;
      end
      chk(h, half);
    end
  endtask : meas

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Tests
  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    settle();
    chk({switch_out, modulated_sel_out, input_p_open_out, input_n_open_out}, 32'h13);
    rd(10'h05c, 32'hffffffff, 32'h00300040);
    rd(10'h060, 32'hffffffff, 32'h00200000);
    $display("Test reset values done");
    // Reserved modulation code 011 is never written
    wr(10'h05c, 32'hffffffff);
    rd(10'h05c, 32'hffffffff, 32'h003f3f73);
    for (int i = 0; i < 8; i++) begin
      wr(10'h05c, mux(1'b1, i[2:0], 3'h4, 2'b00));
      settle();
      chk(nominal_sel_out, i);
      chk(switch_out, 32'he);
    end
    for (int i = 0; i < 8; i++) begin
      if (i != 3) begin
        wr(10'h05c, mux(1'b1, 3'h0, i[2:0], i[1:0]));
        rd(10'h05c, 32'h00000073, {i[2:0], 2'b00, i[1:0]});
        chk(modulated_sel_out, i);
        rd(10'h068, 32'h0000000b, {i < 3, 1'b1});
      end
    end
    $display("Test field codes done");
    wr(10'h064, 32'h1);
    settle();
    chk(switch_out, 32'h0);
    rd(10'h068, 32'h0000000b, 32'h0);
    wr(10'h064, 32'h0);
    wr(10'h05c, mux(1'b0, 3'h2, 3'h0, 2'b00));
    settle();
    chk(switch_out, 32'h0);
    $display("Test gating done");
    meas(0, 1, 1'b1);
    meas(0, 2, 1'b0);
    meas(1, 1, 1'b0);
    tick_all <= 1'b1;
    $display("Test divider done");
    wr(10'h060, 32'h00abcdef);
    rd(10'h060, 32'hffffffff, 32'h00abcdef);
    bus(1'b1, 10'h060, 32'hffffff11, 4'h1, q);
    settle();
    chk(chan_cfg_out, 32'h00abcd11);
    chk(chan_changed_out, 1'b1);
    rd(10'h068, 32'h00000008, 32'h8);
    wr(10'h064, 32'h2);
    #1;
    chk(resync_out, 1'b1);
    @(posedge clk_in);
    #1;
    chk(resync_out, 1'b0);
    settle();
    chk(chan_changed_out, 1'b0);
    wr(10'h070, 32'h00ffffff);
    rd(10'h070, 32'hffffffff, 32'h0);
    wr(10'h05c, 32'h0);
    settle();
    chk({input_p_open_out, input_n_open_out}, 32'h0);
    $display("Test channel register done");
    print_verdict();
  end

  initial begin
    #1500000;
    err_total++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
